// File: rtl/bwc_pkg.sv
// constants shared by the byte-wide configuration port
package bwc_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MODE_W = 3;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned CNT_W = 24;
    localparam int unsigned IRQ_W = 3;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RX_BYTE = 8'h08;
    localparam logic [7:0] ADDR_TX_BYTE = 8'h0c;
    localparam logic [7:0] ADDR_BYTE_CNT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    // control fields
    localparam int unsigned CTRL_DONE_BIT = 0;
    localparam int unsigned CTRL_RETAIN_BIT = 1;
    localparam int unsigned CTRL_CNT_CLR_BIT = 2;
    // status fields
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_RX_FULL_BIT = 1;
    localparam int unsigned ST_TX_FULL_BIT = 2;
    localparam int unsigned ST_ABORT_BIT = 3;
    localparam int unsigned ST_MSERIAL_BIT = 4;
    localparam int unsigned ST_PULLUP_BIT = 5;
    localparam int unsigned ST_SEL_BIT = 6;
    // interrupt event bits
    localparam int unsigned IRQ_RX_BIT = 0;
    localparam int unsigned IRQ_TX_BIT = 1;
    localparam int unsigned IRQ_ABORT_BIT = 2;
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
    // mode pin codes selecting master serial
    localparam logic [MODE_W-1:0] MODE_MSERIAL_A = 3'h0;
    localparam logic [MODE_W-1:0] MODE_MSERIAL_B = 3'h4;
    // mode pin whose low level enables pre-configuration pull-ups
    localparam int unsigned PULLUP_MODE_BIT = 2;
endpackage : bwc_pkg

// File: rtl/bwc_sync_if.sv
// bundle of raw pin levels and their synchronised copies
`timescale 1ns/100ps
`default_nettype none
interface bwc_sync_if #(
    parameter int unsigned WIDTH = 14
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] sync;
    modport src (output raw, input sync);
    modport snk (input raw, output sync);
endinterface : bwc_sync_if
`default_nettype wire

// File: rtl/bwc_pin_sync.sv
// two flip-flop synchroniser for pins entering the clk_i domain
`timescale 1ns/100ps
`default_nettype none
module bwc_pin_sync #(
    parameter int unsigned WIDTH = 14
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pin bundle
    bwc_sync_if.snk pins
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    initial begin
        if (WIDTH < 1) begin
            $error("bwc_pin_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pins.raw;
            sync_ff <= meta_ff;
        end
    end

    assign pins.sync = sync_ff;
endmodule : bwc_pin_sync
`default_nettype wire

// File: rtl/bwc_top.sv
// byte-wide configuration port with wishbone register access
// Function
// - bytes enter one per transfer, paced by busy
// - selected without write strobe drives readback data
// - after done, pins released or kept for readback
// - retain option chosen by software control bit
// - mode codes 000 or 100 select master serial
// - packet resumes across separate select assertions
// - strobe change while selected starts an abort
// - mode_pin_hi_i low enables global pull-ups until done
// - unused outputs high impedance until done
`timescale 1ns/100ps
`default_nettype none
module bwc_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // configuration port pins
    input wire logic config_clock_i,
    input wire logic sel_n_i,
    input wire logic write_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic busy_o,
    // mode pins
    input wire logic mode_pin_hi_i,
    input wire logic mode_pin_mid_i,
    input wire logic mode_pin_lo_i,
    // pad and configuration state
    output logic master_serial_o,
    output logic pullup_en_o,
    output logic pulldown_keeper_en_o,
    output logic user_io_en_o,
    output logic port_pins_user_o,
    // received byte stream
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o
);
    localparam int unsigned DW = bwc_pkg::DATA_W;
    localparam int unsigned SW = 1 + 1 + 1 + DW + bwc_pkg::MODE_W;

    ////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (bwc_pkg::CNT_W > 32) begin : g_cnt_chk
        $error("bwc_top: byte counter wider than the bus word");
    end
    if (bwc_pkg::IRQ_W <= bwc_pkg::IRQ_ABORT_BIT) begin : g_irq_chk
        $error("bwc_top: interrupt field too narrow for its events");
    end
    if (bwc_pkg::SYNC_STAGES != 2) begin : g_sync_chk
        $error("bwc_top: pin synchroniser depth is fixed at two");
    end
    if (bwc_pkg::DATA_W != 8) begin : g_data_chk
        $error("bwc_top: port data bus is byte wide");
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisation

    bwc_sync_if #(.WIDTH(SW)) pin_if ();

    assign pin_if.raw = {config_clock_i, sel_n_i, write_n_i, data_i, mode_pin_hi_i, mode_pin_mid_i, mode_pin_lo_i};

    bwc_pin_sync #(.WIDTH(SW)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pins(pin_if.snk)
    );

    logic s_config_clock;
    logic s_sel_n;
    logic s_wr_n;
    logic [DW-1:0] s_data;
    logic [bwc_pkg::MODE_W-1:0] s_mode;

    assign {s_config_clock, s_sel_n, s_wr_n, s_data, s_mode} = pin_if.sync;

    ////////////////////////////////////////////////////////////////////
    // config clock edge detect

    logic config_clock_prev_ff;
    logic config_clock_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            config_clock_prev_ff <= 1'b0;
        end else begin
            config_clock_prev_ff <= s_config_clock;
        end
    end

    assign config_clock_rise = s_config_clock & ~config_clock_prev_ff;

    ////////////////////////////////////////////////////////////////////
    // control registers

    logic done_ff;
    logic retain_ff;
    logic [bwc_pkg::IRQ_W-1:0] irq_mask_ff;
    logic [bwc_pkg::IRQ_W-1:0] irq_stat_ff;
    logic ack_ff;
    logic bus_acc;
    logic bus_wr;
    logic bus_rd;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction : hit

    assign bus_acc = wb_cyc_i & wb_stb_i & ack_ff;
    assign bus_wr = bus_acc & wb_we_i & wb_sel_i[0];
    assign bus_rd = bus_acc & ~wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
        end
    end

    assign wb_ack_o = ack_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_ff <= bwc_pkg::CTRL_RST[bwc_pkg::CTRL_DONE_BIT];
            retain_ff <= bwc_pkg::CTRL_RST[bwc_pkg::CTRL_RETAIN_BIT];
        end else if (bus_wr && hit(wb_adr_i, bwc_pkg::ADDR_CTRL)) begin
            done_ff <= wb_dat_i[bwc_pkg::CTRL_DONE_BIT];
            retain_ff <= wb_dat_i[bwc_pkg::CTRL_RETAIN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_ff <= bwc_pkg::IRQ_MASK_RST;
        end else if (bus_wr && hit(wb_adr_i, bwc_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_ff <= wb_dat_i[bwc_pkg::IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // port state and pad control

    logic port_active;
    logic sel_act;
    logic rd_dir;

    assign port_active = ~done_ff | retain_ff;
    assign sel_act = ~s_sel_n & port_active;
    assign rd_dir = sel_act & s_wr_n;

    assign master_serial_o = (s_mode == bwc_pkg::MODE_MSERIAL_A) || (s_mode == bwc_pkg::MODE_MSERIAL_B);
    assign pullup_en_o = ~done_ff & ~s_mode[bwc_pkg::PULLUP_MODE_BIT];
    assign pulldown_keeper_en_o = done_ff;
    assign user_io_en_o = done_ff;
    assign port_pins_user_o = done_ff & ~retain_ff;

    ////////////////////////////////////////////////////////////////////
    // transfer engine on config clock rise

    logic sel_prev_ff;
    logic wr_prev_ff;
    logic abort_ff;
    logic busy_ff;
    logic rx_full_ff;
    logic [DW-1:0] rx_byte_ff;
    logic tx_full_ff;
    logic [DW-1:0] tx_byte_ff;
    logic [DW-1:0] rd_data_ff;
    logic [bwc_pkg::CNT_W-1:0] byte_cnt_ff;
    logic strobe_flip;
    logic wr_take;
    logic rd_take;
    logic rx_pop;
    logic tx_load;
    logic nxt_rx_full;

    assign strobe_flip = config_clock_rise & sel_act & sel_prev_ff & (s_wr_n != wr_prev_ff);
    assign wr_take = config_clock_rise & sel_act & ~s_wr_n & ~done_ff & ~abort_ff & ~strobe_flip & ~busy_ff & ~rx_full_ff;
    assign rd_take = config_clock_rise & rd_dir & ~abort_ff & ~strobe_flip & tx_full_ff;
    assign rx_pop = bus_rd & hit(wb_adr_i, bwc_pkg::ADDR_RX_BYTE);
    assign tx_load = bus_wr & hit(wb_adr_i, bwc_pkg::ADDR_TX_BYTE);
    assign nxt_rx_full = wr_take | (rx_full_ff & ~rx_pop);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b1;
        end else if (config_clock_rise) begin
            sel_prev_ff <= sel_act;
            wr_prev_ff <= s_wr_n;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            abort_ff <= 1'b0;
        end else if (strobe_flip) begin
            abort_ff <= 1'b1;
        end else if (config_clock_rise && !sel_act) begin
            abort_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
        end else if (config_clock_rise) begin
            busy_ff <= strobe_flip | abort_ff & sel_act | (rd_dir ? ~tx_full_ff | rd_take : nxt_rx_full);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_full_ff <= 1'b0;
            rx_byte_ff <= bwc_pkg::BYTE_RST;
        end else begin
            rx_full_ff <= nxt_rx_full;
            if (wr_take) begin
                rx_byte_ff <= s_data;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            byte_cnt_ff <= bwc_pkg::CNT_RST;
        end else if (bus_wr && hit(wb_adr_i, bwc_pkg::ADDR_CTRL) && wb_dat_i[bwc_pkg::CTRL_CNT_CLR_BIT]) begin
            byte_cnt_ff <= bwc_pkg::CNT_RST;
        end else if (wr_take) begin
            byte_cnt_ff <= byte_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_full_ff <= 1'b0;
            tx_byte_ff <= bwc_pkg::BYTE_RST;
        end else if (tx_load) begin
            tx_full_ff <= 1'b1;
            tx_byte_ff <= wb_dat_i[DW-1:0];
        end else if (rd_take) begin
            tx_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_ff <= bwc_pkg::BYTE_RST;
        end else if (rd_take) begin
            rd_data_ff <= tx_byte_ff;
        end
    end

    assign data_o = rd_data_ff;
    assign data_oe_o = rd_dir & ~abort_ff;
    assign busy_o = busy_ff;
    assign rx_byte_o = rx_byte_ff;
    assign rx_valid_o = rx_full_ff;

    ////////////////////////////////////////////////////////////////////
    // interrupt status, set wins over clear

    logic [bwc_pkg::IRQ_W-1:0] irq_evt;
    logic [bwc_pkg::IRQ_W-1:0] irq_clr;

    assign irq_evt[bwc_pkg::IRQ_RX_BIT] = wr_take;
    assign irq_evt[bwc_pkg::IRQ_TX_BIT] = rd_take;
    assign irq_evt[bwc_pkg::IRQ_ABORT_BIT] = strobe_flip;
    assign irq_clr = (bus_wr && hit(wb_adr_i, bwc_pkg::ADDR_IRQ_STAT)) ? wb_dat_i[bwc_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
        end
    end

    assign irq_o = |(irq_stat_ff & irq_mask_ff);

    ////////////////////////////////////////////////////////////////////
    // read data

    logic [31:0] rd_mux;
    logic [31:0] rdat_ff;

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (wb_adr_i)
            bwc_pkg::ADDR_CTRL: begin
                rd_mux[bwc_pkg::CTRL_DONE_BIT] = done_ff;
                rd_mux[bwc_pkg::CTRL_RETAIN_BIT] = retain_ff;
            end
            bwc_pkg::ADDR_STATUS: begin
                rd_mux[bwc_pkg::ST_BUSY_BIT] = busy_ff;
                rd_mux[bwc_pkg::ST_RX_FULL_BIT] = rx_full_ff;
                rd_mux[bwc_pkg::ST_TX_FULL_BIT] = tx_full_ff;
                rd_mux[bwc_pkg::ST_ABORT_BIT] = abort_ff;
                rd_mux[bwc_pkg::ST_MSERIAL_BIT] = master_serial_o;
                rd_mux[bwc_pkg::ST_PULLUP_BIT] = pullup_en_o;
                rd_mux[bwc_pkg::ST_SEL_BIT] = sel_act;
            end
            bwc_pkg::ADDR_RX_BYTE: rd_mux[DW-1:0] = rx_byte_ff;
            bwc_pkg::ADDR_TX_BYTE: rd_mux[DW-1:0] = tx_byte_ff;
            bwc_pkg::ADDR_BYTE_CNT: rd_mux[bwc_pkg::CNT_W-1:0] = byte_cnt_ff;
            bwc_pkg::ADDR_IRQ_STAT: rd_mux[bwc_pkg::IRQ_W-1:0] = irq_stat_ff;
            bwc_pkg::ADDR_IRQ_MASK: rd_mux[bwc_pkg::IRQ_W-1:0] = irq_mask_ff;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_ff <= 32'h00000000;
        end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
            rdat_ff <= rd_mux;
        end
    end

    assign wb_dat_o = rdat_ff;
endmodule : bwc_top
`default_nettype wire

// File: dv/bwc_chk.sv
// assertions on the byte-wide configuration port pins
`timescale 1ns/100ps
`default_nettype none
module bwc_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic config_clock_i,
    input wire logic sel_n_i,
    input wire logic write_n_i,
    input wire logic data_oe_o,
    input wire logic busy_o,
    input wire logic mode_pin_hi_i,
    input wire logic mode_pin_mid_i,
    input wire logic mode_pin_lo_i,
    input wire logic master_serial_o,
    input wire logic pullup_en_o,
    input wire logic pulldown_keeper_en_o,
    input wire logic user_io_en_o,
    input wire logic port_pins_user_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic config_clock_ff;
    logic [3:0] since_rise_ff;
    always_ff @(posedge clk_i) begin
        config_clock_ff <= config_clock_i;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            since_rise_ff <= 4'hf;
        end else if (config_clock_i && !config_clock_ff) begin
            since_rise_ff <= 4'h0;
        end else if (since_rise_ff != 4'hf) begin
            since_rise_ff <= since_rise_ff + 4'h1;
        end
    end
    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_mode_steady;
        $stable({mode_pin_hi_i, mode_pin_mid_i, mode_pin_lo_i, user_io_en_o}) [*5];
    endsequence
    chk_ack_next: assert property (s_wb_req |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_mode_serial: assert property (
        s_mode_steady |-> master_serial_o == ({mode_pin_mid_i, mode_pin_lo_i} == 2'h0))
        else $error("master serial decode wrong");
    chk_pullup_mode: assert property (
        s_mode_steady |-> pullup_en_o == (!mode_pin_hi_i && !user_io_en_o))
        else $error("pull-up enable wrong");
    chk_keeper_off: assert property (!user_io_en_o |-> !pulldown_keeper_en_o)
        else $error("keeper active before done");
    chk_retain_pins: assert property (port_pins_user_o |-> user_io_en_o && !pullup_en_o)
        else $error("port pins released too early");
    chk_readback_oe: assert property (
        data_oe_o |-> $past(sel_n_i, 2) == 1'b0 && $past(write_n_i, 2))
        else $error("data driven without readback select");
    chk_busy_edge: assert property ($changed(busy_o) |-> since_rise_ff < 4'h7)
        else $error("busy moved away from a clock rise");
endmodule : bwc_chk
bind bwc_top bwc_chk bwc_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .config_clock_i,
    .sel_n_i, .write_n_i, .data_oe_o, .busy_o, .mode_pin_hi_i, .mode_pin_mid_i, .mode_pin_lo_i,
    .master_serial_o, .pullup_en_o, .pulldown_keeper_en_o, .user_io_en_o, .port_pins_user_o);
`default_nettype wire

// File: dv/bwc_src_model.sv
// behavioural configuration data source on the byte port pins
`timescale 1ns/100ps
`default_nettype none
module bwc_src_model (
    // pins towards the device
    output logic config_clock_o,
    output logic sel_n_o,
    output logic write_n_o,
    output logic [7:0] data_o,
    // pins from the device
    input wire logic busy_i,
    input wire logic [7:0] rb_data_i,
    input wire logic rb_oe_i
);
    logic [7:0] drv_ff = 8'h00;
    logic drv_en_ff = 1'b0;
    initial begin
        config_clock_o = 1'b0;
        sel_n_o = 1'b1;
        write_n_o = 1'b1;
    end
    // released bus shows readback data while rb_oe_i is high, else the inverted last value
    assign data_o = drv_en_ff ? drv_ff : (rb_oe_i ? rb_data_i : ~drv_ff);
    task automatic pulse(input logic s, input logic w, input logic [7:0] d);
        #7;
        sel_n_o = s;
        write_n_o = w;
        drv_en_ff = !w;
        drv_ff = w ? drv_ff : d;
        #100 config_clock_o = 1'b1;
        #100 config_clock_o = 1'b0;
    endtask : pulse
    task automatic put(input logic [7:0] d);
        while (busy_i) begin
            pulse(1'b0, 1'b0, drv_ff);
        end
        pulse(1'b0, 1'b0, d);
    endtask : put
endmodule : bwc_src_model
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the byte-wide configuration port
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, data_oe_o, busy_o;
    logic config_clock_i, sel_n_i, write_n_i, mode_pin_hi_i, mode_pin_mid_i, mode_pin_lo_i;
    logic master_serial_o, pullup_en_o, pulldown_keeper_en_o, user_io_en_o, port_pins_user_o, rx_valid_o;
    logic [7:0] wb_adr_i, data_o, data_i, rx_byte_o;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    int failures = 0;
    int tests_run = 0;
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    bwc_top bwc_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .irq_o, .config_clock_i, .sel_n_i, .write_n_i, .data_i, .data_o, .data_oe_o,
        .busy_o, .mode_pin_hi_i, .mode_pin_mid_i, .mode_pin_lo_i, .master_serial_o, .pullup_en_o,
        .pulldown_keeper_en_o, .user_io_en_o, .port_pins_user_o, .rx_byte_o, .rx_valid_o);
    bwc_src_model bwc_src_model_inst (.config_clock_o(config_clock_i), .sel_n_o(sel_n_i),
        .write_n_o(write_n_i), .data_o(data_i), .busy_i(busy_o), .rb_data_i(data_o), .rb_oe_i(data_oe_o));
    ////////////////////////////////////////////////////////////////
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_reg
    task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_pin
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (!wb_ack_o) @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
        settle();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        cmp_reg(q & m, e);
    endtask : rd
    task automatic settle();
        repeat (4) @(posedge clk_i);
    endtask : settle
    task automatic pls(input logic s, input logic w, input logic [7:0] d);
        bwc_src_model_inst.pulse(s, w, d);
        settle();
    endtask : pls
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hf;
        {mode_pin_hi_i, mode_pin_mid_i, mode_pin_lo_i} = 3'h1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        rd(bwc_pkg::ADDR_CTRL, 32'h0);
        rd(bwc_pkg::ADDR_IRQ_MASK, 32'h0);
        rd(8'h1c, 32'h0);
        for (int i = 0; i < 8; i++) begin
            {mode_pin_hi_i, mode_pin_mid_i, mode_pin_lo_i} <= i[2:0];
            repeat (6) @(posedge clk_i);
            cmp_pin({7'h0, master_serial_o}, {7'h0, i[1:0] == 2'h0});
            cmp_pin({7'h0, pullup_en_o}, {7'h0, !i[2]});
        end
        cmp_pin({6'h0, user_io_en_o, pulldown_keeper_en_o}, 8'h00);
        bwc_src_model_inst.put(8'h5a);
        settle();
        cmp_pin(rx_byte_o, 8'h5a);
        cmp_pin({5'h0, rx_valid_o, busy_o, irq_o}, 8'h06);
        wr(bwc_pkg::ADDR_IRQ_MASK, 32'h7);
        cmp_pin({7'h0, irq_o}, 8'h01);
        wb_sel_i <= 4'he;
        wr(bwc_pkg::ADDR_IRQ_MASK, 32'h0);
        wb_sel_i <= 4'hf;
        rd(bwc_pkg::ADDR_IRQ_MASK, 32'h7);
        pls(1'b0, 1'b0, 8'ha5);
        cmp_pin(rx_byte_o, 8'h5a);
        rd(bwc_pkg::ADDR_RX_BYTE, 32'h5a);
        settle();
        cmp_pin({7'h0, rx_valid_o}, 8'h00);
        bwc_src_model_inst.put(8'hc3);
        rd(bwc_pkg::ADDR_RX_BYTE, 32'hc3);
        pls(1'b1, 1'b1, 8'h00);
        bwc_src_model_inst.put(8'h3c);
        settle();
        rd(bwc_pkg::ADDR_BYTE_CNT, 32'h3);
        rd(bwc_pkg::ADDR_RX_BYTE, 32'h3c);
        wr(bwc_pkg::ADDR_IRQ_STAT, 32'h7);
        cmp_pin({7'h0, irq_o}, 8'h00);
        pls(1'b1, 1'b1, 8'h00);
        pls(1'b0, 1'b1, 8'h00);
        pls(1'b0, 1'b0, 8'h77);
        rd(bwc_pkg::ADDR_STATUS, 32'h8, 32'h8);
        rd(bwc_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
        pls(1'b0, 1'b0, 8'h99);
        rd(bwc_pkg::ADDR_BYTE_CNT, 32'h3);
        pls(1'b1, 1'b1, 8'h00);
        rd(bwc_pkg::ADDR_STATUS, 32'h0, 32'h8);
        wr(bwc_pkg::ADDR_TX_BYTE, 32'h96);
        pls(1'b0, 1'b1, 8'h00);
        cmp_pin(data_i, 8'h96);
        rd(bwc_pkg::ADDR_IRQ_STAT, 32'h2, 32'h2);
        pls(1'b1, 1'b1, 8'h00);
        wr(bwc_pkg::ADDR_CTRL, 32'h3);
        cmp_pin({6'h0, user_io_en_o, port_pins_user_o}, 8'h02);
        pls(1'b0, 1'b0, 8'he7);
        rd(bwc_pkg::ADDR_BYTE_CNT, 32'h3);
        pls(1'b1, 1'b1, 8'h00);
        wr(bwc_pkg::ADDR_TX_BYTE, 32'h69);
        pls(1'b0, 1'b1, 8'h00);
        cmp_pin(data_i, 8'h69);
        pls(1'b1, 1'b1, 8'h00);
        wr(bwc_pkg::ADDR_CTRL, 32'h1);
        cmp_pin({6'h0, pulldown_keeper_en_o, port_pins_user_o}, 8'h03);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
